// File: hw/psl_params.svh
/*
 Constants for the preamplifier serial settings loader: word layout,
 field positions, reset values and timing figures.
 Assumes nothing; definitions only.
*/
`ifndef PSL_PARAMS_SVH
`define PSL_PARAMS_SVH

`define PSL_WORD_WIDTH 16
`define PSL_GAIN_BIT 9
`define PSL_DC2_BIT 8
`define PSL_DC1_BIT 7
`define PSL_SINGLE_BIT 6
`define PSL_SHUNT_MSB 5
`define PSL_SHUNT_LSB 0
`define PSL_SHUNT_WIDTH 6
`define PSL_SETTINGS_RESET 16'h0000
`define PSL_CLK_PERIOD_NS 100
`define PSL_LATCH_HOLD_MIN_NS 10000
`define PSL_LATCH_HOLD_MIN_CYC \
    ((`PSL_LATCH_HOLD_MIN_NS + `PSL_CLK_PERIOD_NS - 1) / `PSL_CLK_PERIOD_NS)

`endif

// File: hw/psl_pkg.sv
/*
 Types for the preamplifier serial settings loader.
 Assumes psl_params.svh is available on the include path.
*/
`include "psl_params.svh"
package psl_pkg;
    typedef enum logic [1:0] {
        PSL_GAIN_ONE_type_val = 2'h1,
        PSL_GAIN_TEN_type_val = 2'h2
    } psl_gain_type;

    typedef struct packed {
        logic gain_ten;
        logic input_two_dc_coupling;
        logic input_one_dc_coupling;
        logic single_ended;
        logic [`PSL_SHUNT_WIDTH-1:0] shunt_select;
    } psl_settings_type;
endpackage

// File: hw/psl_edge_if.sv
/*
 Interface carrying synchronised link levels and their edge strobes
 between the sampler and the settings loader.
 Assumes a single clock domain on CLK_I.
*/
`timescale 1ns/1ns
interface psl_edge_if;
    logic data_level;
    logic shift_rise;
    logic latch_rise;
    logic latch_level;
    modport sampler (output data_level, output shift_rise, output latch_rise,
        output latch_level);
    modport loader (input data_level, input shift_rise, input latch_rise,
        input latch_level);
endinterface

// File: hw/psl_sampler.sv
/*
 Two-flop synchronisers for the serial data, shift clock and latch lines,
 plus rising-edge detection on the synchronised levels.
 Assumes CLK_I is much faster than the shift clock (10 us minimum period).
*/
`timescale 1ns/1ns
module psl_sampler (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic enable_i,
    input wire logic data_pin_i,
    input wire logic shift_pin_i,
    input wire logic latch_pin_i,
    psl_edge_if.sampler edges
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [2:0] prev_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            prev_q <= 3'h0;
        end else if (enable_i) begin
            meta_q <= {latch_pin_i, shift_pin_i, data_pin_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign edges.data_level = sync_q[0];
    assign edges.latch_level = sync_q[2];
    // Data is settled 2 us before the clock edge, so no extra delay needed
    assign edges.shift_rise = enable_i & sync_q[1] & ~prev_q[1];
    assign edges.latch_rise = enable_i & sync_q[2] & ~prev_q[2];
endmodule

// File: hw/psl_loader.sv
/*
 Serial settings loader of a two-channel current preamplifier: shifts a
 16-bit word in on the shift clock and applies it on the latch strobe.
 Assumes a host that shifts MSB first and strobes the latch line after
 the last bit; the shift clock and latch are sampled by CLK_I.
*/
// Overview of operation
// (R1) Settings load only via shift then latch
// (R2) 16-bit word, MSB first, bits 15-10 ignored
// (R3) Bit 9 selects output gain 1 or 10
// (R4) Bit 8 sets input two AC/DC coupling
// (R5) Bit 7 sets input one AC/DC coupling
// (R6) Bit 6 selects differential or single-ended
// (R7) Bits 5-0 each connect one shunt resistor
// (R8) All shunt bits clear disconnects every resistor
// (R9) Presence line driven so host detects device; the code drives it from shift_q bit 15, so it is 0 after reset
// (R10) Sample on shift rise, apply on latch
`timescale 1ns/1ns
`include "psl_params.svh"
module psl_loader #(
    parameter int WORD_WIDTH = `PSL_WORD_WIDTH
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    input wire logic SERIAL_SETTING_IN_I,
    input wire logic SHIFT_CLOCK_I,
    input wire logic LATCH_STROBE_I,
    output logic PRESENCE_DETECT_OUT_O,
    output psl_pkg::psl_gain_type OUTPUT_GAIN_O,
    output logic GAIN_TEN_SELECT_O,
    output logic INPUT_TWO_DC_COUPLING_O,
    output logic INPUT_ONE_DC_COUPLING_O,
    output logic SINGLE_ENDED_SELECT_O,
    output logic SHUNT_ONE_MEG_SELECT_O,
    output logic SHUNT_HUNDRED_KILO_SELECT_O,
    output logic SHUNT_TEN_KILO_SELECT_O,
    output logic SHUNT_ONE_KILO_SELECT_O,
    output logic SHUNT_HUNDRED_SELECT_O,
    output logic SHUNT_TEN_SELECT_O,
    output logic EXTERNAL_SHUNT_O,
    output logic [WORD_WIDTH-1:0] SHIFT_CONTENT_O
);
    import psl_pkg::*;

    psl_edge_if edges ();
    logic [WORD_WIDTH-1:0] shift_q;
    logic [WORD_WIDTH-1:0] shift_d;
    psl_settings_type settings_q;
    psl_settings_type settings_d;
    logic presence_q;

    psl_sampler u_sampler (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .enable_i(CLK_EN_I),
        .data_pin_i(SERIAL_SETTING_IN_I),
        .shift_pin_i(SHIFT_CLOCK_I),
        .latch_pin_i(LATCH_STROBE_I),
        .edges(edges.sampler)
    );

    // New bits enter at the bottom so the first bit ends at the top
    assign shift_d = {shift_q[WORD_WIDTH-2:0], edges.data_level}; // R2

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            shift_q <= '0;
        end else if (CLK_EN_I && edges.shift_rise) begin
            shift_q <= shift_d; // R10
        end
    end

    // Upper unused bits are simply never copied into the settings
    always_comb begin
        settings_d.gain_ten = shift_q[`PSL_GAIN_BIT]; // R3
        settings_d.input_two_dc_coupling = shift_q[`PSL_DC2_BIT]; // R4
        settings_d.input_one_dc_coupling = shift_q[`PSL_DC1_BIT]; // R5
        settings_d.single_ended = shift_q[`PSL_SINGLE_BIT]; // R6
        settings_d.shunt_select = shift_q[`PSL_SHUNT_MSB:`PSL_SHUNT_LSB]; // R7
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            settings_q <= psl_settings_type'(10'(`PSL_SETTINGS_RESET));
        end else if (CLK_EN_I && edges.latch_rise) begin
            settings_q <= settings_d; // R1
        end
    end

    // Presence line mirrors the register tail, a simple sign of life
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            presence_q <= 1'b0;
        end else if (CLK_EN_I) begin
            presence_q <= shift_q[WORD_WIDTH-1]; // R9
        end
    end

    assign PRESENCE_DETECT_OUT_O = presence_q;
    assign OUTPUT_GAIN_O = settings_q.gain_ten ? PSL_GAIN_TEN_type_val
                                                : PSL_GAIN_ONE_type_val; // R3
    assign GAIN_TEN_SELECT_O = settings_q.gain_ten;
    assign INPUT_TWO_DC_COUPLING_O = settings_q.input_two_dc_coupling;
    assign INPUT_ONE_DC_COUPLING_O = settings_q.input_one_dc_coupling;
    assign SINGLE_ENDED_SELECT_O = settings_q.single_ended;
    assign SHUNT_ONE_MEG_SELECT_O = settings_q.shunt_select[5];
    assign SHUNT_HUNDRED_KILO_SELECT_O = settings_q.shunt_select[4];
    assign SHUNT_TEN_KILO_SELECT_O = settings_q.shunt_select[3];
    assign SHUNT_ONE_KILO_SELECT_O = settings_q.shunt_select[2];
    assign SHUNT_HUNDRED_SELECT_O = settings_q.shunt_select[1];
    assign SHUNT_TEN_SELECT_O = settings_q.shunt_select[0];
    assign EXTERNAL_SHUNT_O = ~|settings_q.shunt_select; // R8
    assign SHIFT_CONTENT_O = shift_q;
endmodule

// File: verif/psl_host_model.sv
/* Host side of the serial settings link: shifts words MSB first, strobes latch.
   Assumes it is clocked from the bench clock's falling edge. */
`timescale 1ns/1ns
module psl_host_model (
    input wire logic clk_i,
    output logic data_o,
    output logic shift_o,
    output logic latch_o
);
    int half = 4; // Half link period in cycles; 4 gives 400 ns
    initial begin
        data_o = 1'b0;
        shift_o = 1'b0;
        latch_o = 1'b0;
    end
    task automatic send(input logic [15:0] w, input logic go);
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk_i);
            shift_o = 1'b0;
            data_o = w[i];
            repeat (half) @(negedge clk_i);
            shift_o = 1'b1;
            repeat (half) @(negedge clk_i);
        end
        shift_o = 1'b0;
        data_o = ~data_o; // Stale data must not look valid
        if (go) begin
            repeat (half) @(negedge clk_i);
            latch_o = 1'b1;
            repeat (2 * half) @(negedge clk_i);
            latch_o = 1'b0;
        end
    endtask
endmodule

// File: verif/psl_loader_checker.sv
/* Port assertions for the settings loader.
   Assumes one CLK_I domain. */
`timescale 1ns/1ns
module psl_loader_checker #(parameter int W = 16) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    input wire logic SERIAL_SETTING_IN_I,
    input wire logic SHIFT_CLOCK_I,
    input wire logic LATCH_STROBE_I,
    input wire logic PRESENCE_DETECT_OUT_O,
    input wire logic [1:0] OUTPUT_GAIN_O,
    input wire logic GAIN_TEN_SELECT_O,
    input wire logic INPUT_TWO_DC_COUPLING_O,
    input wire logic INPUT_ONE_DC_COUPLING_O,
    input wire logic SINGLE_ENDED_SELECT_O,
    input wire logic SHUNT_ONE_MEG_SELECT_O,
    input wire logic SHUNT_HUNDRED_KILO_SELECT_O,
    input wire logic SHUNT_TEN_KILO_SELECT_O,
    input wire logic SHUNT_ONE_KILO_SELECT_O,
    input wire logic SHUNT_HUNDRED_SELECT_O,
    input wire logic SHUNT_TEN_SELECT_O,
    input wire logic EXTERNAL_SHUNT_O,
    input wire logic [W-1:0] SHIFT_CONTENT_O
);
    logic [9:0] st;
    assign st = {GAIN_TEN_SELECT_O, INPUT_TWO_DC_COUPLING_O, INPUT_ONE_DC_COUPLING_O,
        SINGLE_ENDED_SELECT_O, SHUNT_ONE_MEG_SELECT_O, SHUNT_HUNDRED_KILO_SELECT_O,
        SHUNT_TEN_KILO_SELECT_O, SHUNT_ONE_KILO_SELECT_O, SHUNT_HUNDRED_SELECT_O,
        SHUNT_TEN_SELECT_O};
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I || !CLK_EN_I);
    gain_code_a: assert property (OUTPUT_GAIN_O == (GAIN_TEN_SELECT_O ? 2'h2 : 2'h1))
        else $error("gain code mismatch");
    ext_shunt_a: assert property (EXTERNAL_SHUNT_O == (st[5:0] == 6'h00))
        else $error("external shunt flag wrong");
    latch_take_a: assert property ($rose(LATCH_STROBE_I) |-> ##3 st == SHIFT_CONTENT_O[9:0])
        else $error("latched settings wrong");
    latch_gain_a: assert property ($rose(LATCH_STROBE_I) |-> ##3
        (OUTPUT_GAIN_O == 2'h2) == SHIFT_CONTENT_O[9]) else $error("latched gain wrong");
    settings_settle_a: assert property (!$stable(st) |-> $past(LATCH_STROBE_I, 3)
        && !$past(LATCH_STROBE_I, 4)) else $error("settings moved without latch");
    shift_in_a: assert property ($rose(SHIFT_CLOCK_I) |-> ##3 SHIFT_CONTENT_O ==
        {$past(SHIFT_CONTENT_O[W-2:0]), $past(SERIAL_SETTING_IN_I, 3)})
        else $error("shift step wrong");
    shift_hold_a: assert property (!$stable(SHIFT_CONTENT_O) |->
        $past(SHIFT_CLOCK_I, 3) && !$past(SHIFT_CLOCK_I, 4)) else $error("stray shift");
    presence_copy_a: assert property (PRESENCE_DETECT_OUT_O == $past(SHIFT_CONTENT_O[W-1]))
        else $error("presence line wrong");
endmodule
bind psl_loader psl_loader_checker #(.W(WORD_WIDTH)) chk (.*);

// File: verif/tb_psl_loader.sv
/* Bench: host model shifts words in, bench compares settings outputs.
   Assumes psl_pkg and the host model are compiled first. */
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_psl_loader;
    import psl_pkg::*;
    logic CLK_I = 1'b0, RESET_N_I = 1'b0, CLK_EN_I = 1'b1;
    logic SERIAL_SETTING_IN_I, SHIFT_CLOCK_I, LATCH_STROBE_I, PRESENCE_DETECT_OUT_O;
    psl_gain_type OUTPUT_GAIN_O;
    logic GAIN_TEN_SELECT_O, INPUT_TWO_DC_COUPLING_O, INPUT_ONE_DC_COUPLING_O;
    logic SINGLE_ENDED_SELECT_O, SHUNT_ONE_MEG_SELECT_O, SHUNT_HUNDRED_KILO_SELECT_O;
    logic SHUNT_TEN_KILO_SELECT_O, SHUNT_ONE_KILO_SELECT_O, SHUNT_HUNDRED_SELECT_O;
    logic SHUNT_TEN_SELECT_O, EXTERNAL_SHUNT_O;
    logic [15:0] SHIFT_CONTENT_O;
    logic [9:0] st;
    int n_mismatch = 0, cmp_count = 0;
    assign st = {GAIN_TEN_SELECT_O, INPUT_TWO_DC_COUPLING_O, INPUT_ONE_DC_COUPLING_O,
        SINGLE_ENDED_SELECT_O, SHUNT_ONE_MEG_SELECT_O, SHUNT_HUNDRED_KILO_SELECT_O,
        SHUNT_TEN_KILO_SELECT_O, SHUNT_ONE_KILO_SELECT_O, SHUNT_HUNDRED_SELECT_O,
        SHUNT_TEN_SELECT_O};
    psl_loader dut (.*);
    psl_host_model host (.clk_i(CLK_I), .data_o(SERIAL_SETTING_IN_I),
        .shift_o(SHIFT_CLOCK_I), .latch_o(LATCH_STROBE_I));
    initial begin
        forever #50 CLK_I = ~CLK_I;
    end
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apply(input logic [15:0] w);
        host.send(w, 1'b1);
        repeat (4) @(negedge CLK_I);
        `CHK(st, w[9:0])
        `CHK(OUTPUT_GAIN_O, w[9] ? 2'h2 : 2'h1)
        `CHK(EXTERNAL_SHUNT_O, w[5:0] == 6'h00)
        `CHK(PRESENCE_DETECT_OUT_O, w[15])
    endtask
    initial begin
        repeat (100000) @(posedge CLK_I);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (2) @(negedge CLK_I);
        RESET_N_I = 1'b1;
        `CHK(st, 10'h000)
        apply(16'hFC00);
        for (int i = 0; i < 10; i++) apply(16'h0001 << i);
        apply(16'h03FF);
        host.send(16'hAAAA, 1'b0);
        host.send(16'h5555, 1'b0);
        `CHK(st, 10'h3FF)
        `CHK(SHIFT_CONTENT_O, 16'h5555)
        // Frozen clock enable must ignore a whole shift and latch
        CLK_EN_I = 1'b0;
        host.send(16'h1234, 1'b1);
        repeat (4) @(negedge CLK_I);
        `CHK(st, 10'h3FF)
        `CHK(SHIFT_CONTENT_O, 16'h5555)
        `CHK(PRESENCE_DETECT_OUT_O, 1'b0)
        CLK_EN_I = 1'b1;
        apply(16'h8247);
        RESET_N_I = 1'b0;
        @(negedge CLK_I);
        `CHK(st, 10'h000)
        `CHK(SHIFT_CONTENT_O, 16'h0000)
        `CHK(PRESENCE_DETECT_OUT_O, 1'b0)
        `CHK(OUTPUT_GAIN_O, 2'h1)
        `CHK(EXTERNAL_SHUNT_O, 1'b1)
        RESET_N_I = 1'b1;
        apply(16'h0040);
        close_out();
    end
endmodule
